// ### tb/rxai_host_model.sv
// Host model: register master that services the alarm interrupt block.
// Assumes read data stand only in the cycle after each read strobe.
`timescale 1ns/10ps
`default_nettype none
module rxai_host_model import rxai_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic [7:0] rd_data_in,
  output logic [7:0] addr_out,
  output logic [7:0] wr_data_out,
  output logic wr_en_out,
  output logic rd_en_out,
  output logic rsp_valid_out,
  output logic [7:0] rsp_data_out
);
  logic rd_q_reg; // Read strobe delayed one cycle
  logic [7:0] rd_addr_reg; // Bus address delayed one cycle
  int msg_cnt; // Far-end messages the host would have sent
  initial begin
    addr_out = 8'h00;
    wr_data_out = 8'h00;
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    msg_cnt = 0;
  end
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  // One-cycle write; lines flip afterwards so stale values never help
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr_out <= a;
    wr_data_out <= d;
    wr_en_out <= 1'b1;
    @(posedge ref_clk_in);
    wr_en_out <= 1'b0;
    addr_out <= ~a;
    wr_data_out <= ~d;
  endtask
  // One-cycle read; the answer is picked up by the bench monitor
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk_in);
    addr_out <= a;
    rd_en_out <= 1'b1;
    @(posedge ref_clk_in);
    rd_en_out <= 1'b0;
    addr_out <= ~a;
  endtask
  // Answer valid only in the cycle after the strobe
  always_ff @(posedge ref_clk_in) begin
    rd_q_reg <= rd_en_out;
    rd_addr_reg <= addr_out;
  end
  assign rsp_valid_out = rd_q_reg;
  assign rsp_data_out = rd_data_in;
  always @(posedge ref_clk_in) begin
    if (rd_q_reg && rd_addr_reg == RXAI_OFF_FLAGS && (rd_data_in & 8'h30) != 8'h00) begin
      msg_cnt <= msg_cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ### tb/tb.sv
// Testbench: drives frame and framing-bit events, checks flags and pins.
// Assumes the host model owns the register port of the block.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import rxai_pkg::*;
  logic ref_clk_in, rst_in, frame_in, ais_in, idle_in, fbit_in, fbit_err_in, in_frame_in, los_in;
  logic [7:0] addr, wdata, rd_data, rsp_d, outs, v;
  logic wr_en, rd_en, rsp_v, int_n, remote_fail, ais_st, idle_st, oof_st;
  logic [2:0] fcfg;
  logic [7:0] exp_q[$]; // Expected read data, oldest first
  int error_cnt, checks_done, seed;
  // Packed pins: remote, alarm, idle, out-of-frame, request
  assign outs = {3'h0, remote_fail, ais_st, idle_st, oof_st, int_n};
  rxai_alarm_irq uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .frame_in(frame_in),
    .ais_pattern_in(ais_in), .idle_pattern_in(idle_in), .fbit_in(fbit_in),
    .fbit_err_in(fbit_err_in), .in_frame_in(in_frame_in), .signal_loss_state_in(los_in),
    .addr_in(addr), .wr_data_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en),
    .rd_data_out(rd_data), .int_n_out(int_n), .remote_fail_out(remote_fail),
    .alarm_indication_state_out(ais_st), .idle_pattern_state_out(idle_st),
    .out_of_frame_state_out(oof_st), .framing_cfg_out(fcfg));
  rxai_host_model host (.ref_clk_in(ref_clk_in), .rd_data_in(rd_data), .addr_out(addr),
    .wr_data_out(wdata), .wr_en_out(wr_en), .rd_en_out(rd_en), .rsp_valid_out(rsp_v),
    .rsp_data_out(rsp_d));
  // ----------------------------------------
  // Clock, helpers, monitor
  // ----------------------------------------
  always #12.5 ref_clk_in = ~ref_clk_in;
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Note the expectation, then read through the host
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask
  // Step past the next edge so registered outputs have landed
  task automatic nxt;
    @(posedge ref_clk_in);
    #1;
  endtask
  // Frames with random gaps; pattern lines scramble in gaps, only the alarm line after the run
  task automatic frames(input int n, input logic a, input logic i);
    repeat (n) begin
      @(posedge ref_clk_in);
      frame_in <= 1'b1;
      ais_in <= a;
      idle_in <= i;
      if ($random(seed) & 1) begin
        @(posedge ref_clk_in);
        frame_in <= 1'b0;
        ais_in <= ~a;
        idle_in <= ~i;
      end
    end
    @(posedge ref_clk_in);
    frame_in <= 1'b0;
    ais_in <= ~a;
  endtask
  task automatic fbits(input int n, input logic e);
    repeat (n) begin
      @(posedge ref_clk_in);
      fbit_in <= 1'b1;
      fbit_err_in <= e;
    end
    @(posedge ref_clk_in);
    fbit_in <= 1'b0;
    fbit_err_in <= ~e;
  endtask
  // Each read answer takes the oldest note
  always @(posedge ref_clk_in) begin
    if (rsp_v === 1'b1) begin
      if (exp_q.size() == 0) begin
        cmp(rsp_d, 8'hxx);
      end else begin
        cmp(rsp_d, exp_q.pop_front());
      end
    end
  end
  task automatic conclude;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Watchdog well beyond the several hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    error_cnt++;
    conclude;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {ref_clk_in, frame_in, ais_in, idle_in, fbit_in, fbit_err_in, in_frame_in} = 7'h00;
    error_cnt = 0;
    checks_done = 0;
    seed = 22270;
    los_in = 1'($random(seed));
    rst_in = 1'b1;
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rdc(RXAI_OFF_IEN, RXAI_IEN_RST);
    rdc(RXAI_OFF_FLAGS, RXAI_FLAGS_RST);
    rdc(RXAI_OFF_CFG, {1'b0, los_in, 6'h00});
    rdc(8'h11, 8'h00);
    nxt;
    cmp(outs, 8'h01);
    // Random enable pattern reads back; status bits ignore writes
    v = 8'($random(seed));
    host.wr(RXAI_OFF_IEN, v);
    rdc(RXAI_OFF_IEN, v);
    host.wr(RXAI_OFF_CFG, 8'hff);
    rdc(RXAI_OFF_CFG, {1'b0, los_in, 6'h07});
    cmp({5'h00, fcfg}, 8'h07);
    host.wr(RXAI_OFF_CFG, 8'h02);
    host.wr(RXAI_OFF_IEN, 8'h20);
    // A clean frame breaks the run, so 62 more do not declare
    frames(40, 1'b1, 1'b0);
    frames(1, 1'b0, 1'b0);
    frames(62, 1'b1, 1'b0);
    nxt;
    nxt;
    cmp(outs, 8'h01);
    frames(1, 1'b1, 1'b0);
    nxt;
    cmp(outs, 8'h18);
    rdc(RXAI_OFF_FLAGS, 8'h20);
    rdc(RXAI_OFF_FLAGS, 8'h00);
    rdc(RXAI_OFF_CFG, {1'b1, los_in, 6'h02});
    cmp(outs, 8'h19);
    frames(62, 1'b0, 1'b0);
    nxt;
    nxt;
    cmp(outs, 8'h19);
    frames(1, 1'b0, 1'b0);
    nxt;
    cmp(outs, 8'h00);
    rdc(RXAI_OFF_FLAGS, 8'h20);
    // Idle change with its enable off: flag only, then pending flag raises
    frames(63, 1'b0, 1'b1);
    nxt;
    cmp(outs, 8'h05);
    host.wr(RXAI_OFF_IEN, 8'h30);
    nxt;
    cmp(outs, 8'h04);
    host.wr(RXAI_OFF_IEN, 8'h00);
    nxt;
    cmp(outs, 8'h05);
    rdc(RXAI_OFF_FLAGS, 8'h10);
    host.wr(RXAI_OFF_IEN, 8'h10);
    frames(62, 1'b0, 1'b0);
    nxt;
    nxt;
    cmp(outs, 8'h05);
    frames(1, 1'b0, 1'b0);
    nxt;
    cmp(outs, 8'h00);
    host.wr(RXAI_OFF_FLAGS, 8'h10);
    rdc(RXAI_OFF_FLAGS, 8'h00);
    cmp(outs, 8'h01);
    // Out of frame, six of sixteen, then three of sixteen
    fbits(16, 1'b0);
    fbits(5, 1'b1);
    nxt;
    cmp(outs, 8'h01);
    fbits(1, 1'b1);
    nxt;
    cmp(outs, 8'h13);
    rdc(RXAI_OFF_CFG, {1'b0, los_in, 6'h12});
    fbits(16, 1'b0);
    @(posedge ref_clk_in);
    in_frame_in <= 1'b1;
    @(posedge ref_clk_in);
    in_frame_in <= 1'b0;
    nxt;
    cmp(outs, 8'h01);
    host.wr(RXAI_OFF_CFG, 8'h00);
    fbits(2, 1'b1);
    nxt;
    cmp(outs, 8'h01);
    fbits(1, 1'b1);
    nxt;
    cmp(outs, 8'h13);
    repeat (4) nxt;
    cmp(8'(host.msg_cnt), 8'h03);
    conclude;
  end
endmodule
`default_nettype wire

// ### verilog/rxai_alarm_irq.sv
// Receive alarm monitor: alarm and idle conditions, interrupts, registers.
// Assumes frame and framing-bit strobes synchronous to ref_clk_in,
// and a register master that never issues read and write together.
`timescale 1ns/10ps
`default_nettype none
module rxai_alarm_irq import rxai_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Receive stream events
  input wire logic frame_in,
  input wire logic ais_pattern_in,
  input wire logic idle_pattern_in,
  input wire logic fbit_in,
  input wire logic fbit_err_in,
  input wire logic in_frame_in,
  input wire logic signal_loss_state_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [7:0] rd_data_out,
  // Status and control outputs
  output logic int_n_out,
  output logic remote_fail_out,
  output logic alarm_indication_state_out,
  output logic idle_pattern_state_out,
  output logic out_of_frame_state_out,
  output logic [2:0] framing_cfg_out
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] ien; // Interrupt enables
    logic [7:0] flags; // Sticky interrupt flags
    logic [2:0] cfg; // Framing options
    logic [7:0] rdata; // Read data, one cycle
    logic int_n; // Interrupt request, low active
    logic ferf; // Remote failure request
    logic ais; // Mirrored alarm state
    logic idle; // Mirrored idle state
    logic oof; // Mirrored out-of-frame
  } rxai_top_t;
  rxai_top_t st_reg, st_next;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  // 0x10 configuration and alarm state:
  //   bit 7 alarm indication state, read only
  //   bit 6 signal loss state, taken from the input pin
  //   bit 5 idle pattern state, read only
  //   bit 4 out-of-frame state, read only
  //   bit 3 reserved, reads zero
  //   bits 2:0 framing options, read and write
  //   bit 1 picks six of sixteen errors, else three
  // 0x12 interrupt enables, all eight bits read and write;
  //   only bit 5 (alarm) and bit 4 (idle) gate the request
  // 0x13 interrupt flags, cleared by a read of the register;
  //   writing ones clears the matching flags as well
  //   bit 5 alarm change, bit 4 idle change, others zero
  // Any other address reads zero and ignores writes
  //
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  // Frame n of a run is counted at the edge that samples it;
  // the detector toggles on the 63rd and pulses its change line.
  // One edge later the flag, the request and the mirrored state
  // all move together, so software never sees a flag whose
  // state bit has not caught up yet.
  // Read data stand for the single cycle after the strobe and
  // are zero otherwise; the master must take them there.
  // Writes land at the strobe edge and act from the next cycle.
  //
  // ----------------------------------------
  // Limitations
  // ----------------------------------------
  // The signal loss state is only reflected for reading; its
  // own change interrupt lives in another block.
  // A flag read in the same cycle as a new event keeps the new
  // event, at the cost of a read value that does not show it;
  // the next read does.
  // Far-end failure has no disable: it follows alarm and
  // out-of-frame whenever either is declared.

  logic ais_state; // Alarm detector state
  logic ais_chg; // Alarm change pulse
  logic idle_state; // Idle detector state
  logic idle_chg; // Idle change pulse
  logic oof_state; // Out-of-frame state
  logic rd_flags; // Read of flag register
  logic [7:0] set_vec; // Flag set requests
  logic [7:0] clr_vec; // Flag clear requests

  // ----------------------------------------
  // Condition detectors
  // ----------------------------------------
  // Alarm indication run detector
  rxai_frame_cond u_ais (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .frame_in(frame_in),
    .pattern_in(ais_pattern_in),
    .state_out(ais_state),
    .change_out(ais_chg)
  );

  // Idle pattern run detector
  rxai_frame_cond u_idle (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .frame_in(frame_in),
    .pattern_in(idle_pattern_in),
    .state_out(idle_state),
    .change_out(idle_chg)
  );

  // Framing loss detector; sync option picks six
  rxai_oof_det u_oof (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .fbit_in(fbit_in),
    .fbit_err_in(fbit_err_in),
    .six_sel_in(st_reg.cfg[RXAI_CFG_FSYNC]),
    .in_frame_in(in_frame_in),
    .oof_out(oof_state)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Flags are set on every change, enabled or not,
  // so software can poll with interrupts masked
  always_comb begin
    st_next = st_reg;
    set_vec = 8'h00;
    clr_vec = 8'h00;
    rd_flags = rd_en_in && (addr_in == RXAI_OFF_FLAGS);
    st_next.rdata = 8'h00;
    set_vec[RXAI_IRQ_AIS] = ais_chg;
    set_vec[RXAI_IRQ_IDLE] = idle_chg;

    // Register writes
    if (wr_en_in) begin
      if (addr_in == RXAI_OFF_CFG) begin
        // Only the low three bits are writable
        st_next.cfg = wr_data_in[2:0];
      end else if (addr_in == RXAI_OFF_IEN) begin
        st_next.ien = wr_data_in;
      end else if (addr_in == RXAI_OFF_FLAGS) begin
        // Write one to clear as well
        clr_vec = wr_data_in;
      end
    end

    // Register reads, data valid next cycle
    if (rd_en_in) begin
      if (addr_in == RXAI_OFF_CFG) begin
        // present alarm state at bit 7
        st_next.rdata[RXAI_CFG_AIS] = ais_state;
        st_next.rdata[RXAI_CFG_LOS] = signal_loss_state_in;
        st_next.rdata[RXAI_CFG_IDLE] = idle_state;
        st_next.rdata[RXAI_CFG_OOF] = oof_state;
        st_next.rdata[2:0] = st_reg.cfg;
      end else if (addr_in == RXAI_OFF_IEN) begin
        st_next.rdata = st_reg.ien;
      end else if (addr_in == RXAI_OFF_FLAGS) begin
        st_next.rdata = st_reg.flags;
      end else begin
        // Unmapped addresses read zero
        st_next.rdata = 8'h00;
      end
    end

    // read clears, a new event wins
    if (rd_flags) begin
      clr_vec = 8'hff;
    end
    st_next.flags = (st_reg.flags & ~clr_vec) | set_vec;

    // The request is worked out from the next flags and
    // enables, so it moves in the same cycle as the flag
    // and needs no extra stage behind the register
    // enabled flags drive request
    st_next.int_n = ~|(st_next.flags & st_next.ien);

    // Detector states are already registered, so the far-end
    // failure and the mirrors share one edge and cannot skew
    // automatic remote failure
    st_next.ferf = ais_state | oof_state;
    st_next.ais = ais_state;
    st_next.idle = idle_state;
    st_next.oof = oof_state;
  end

  // ----------------------------------------
  // Reset policy
  // ----------------------------------------
  // Reset is synchronous and only loads constants, so the
  // request pin is high and far-end failure low from the first
  // edge of reset on; the detectors reset in step with this.
  // Each field is named below rather than a whole-struct load,
  // which keeps the reset value of every field next to its name.

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_reg.ien <= RXAI_IEN_RST;
      st_reg.flags <= RXAI_FLAGS_RST;
      st_reg.cfg <= RXAI_CFG_RST;
      st_reg.rdata <= 8'h00;
      st_reg.int_n <= 1'b1;
      st_reg.ferf <= 1'b0;
      st_reg.ais <= 1'b0;
      st_reg.idle <= 1'b0;
      st_reg.oof <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------
  assign rd_data_out = st_reg.rdata;
  assign int_n_out = st_reg.int_n;
  // Mirror lags detector by one cycle, so ferf and state align
  assign remote_fail_out = st_reg.ferf;
  assign alarm_indication_state_out = st_reg.ais;
  assign idle_pattern_state_out = st_reg.idle;
  assign out_of_frame_state_out = st_reg.oof;
  assign framing_cfg_out = st_reg.cfg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // All checks run on the one clock and rest during reset.
  // They watch registered state, so a check that looks one
  // edge ahead sees exactly what software would read there.
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  a_int_follows_flags: assert property (
    ##1 (int_n_out == !(|(st_reg.flags & st_reg.ien)))
  ) else $error("interrupt pin disagrees with flags");

  a_ais_sets_flag: assert property (
    ais_chg |=> st_reg.flags[RXAI_IRQ_AIS]
  ) else $error("alarm change did not set its flag");

  a_idle_sets_flag: assert property (
    idle_chg |=> st_reg.flags[RXAI_IRQ_IDLE]
  ) else $error("idle change did not set its flag");

  a_read_clears_flag: assert property (
    rd_en_in && addr_in == RXAI_OFF_FLAGS && !ais_chg && !idle_chg
    |=> st_reg.flags == 8'h00 && rd_data_out == $past(st_reg.flags)
  ) else $error("flag read did not clear flags");

  a_ferf_tracks_alarm: assert property (
    alarm_indication_state_out |-> remote_fail_out
  ) else $error("remote failure missing during alarm");

  a_ferf_tracks_frame: assert property (
    remote_fail_out == (alarm_indication_state_out | out_of_frame_state_out)
  ) else $error("remote failure not tied to alarm or framing");

  a_enable_write: assert property (
    wr_en_in && addr_in == RXAI_OFF_IEN |=> st_reg.ien == $past(wr_data_in)
  ) else $error("enable register not written");

  a_state_readback: assert property (
    rd_en_in && addr_in == RXAI_OFF_CFG |=> rd_data_out[7] == $past(ais_state)
  ) else $error("alarm state bit wrong on read");

  a_masked_quiet: assert property (
    st_reg.ien[5:4] == 2'b00 && $past(st_next.ien[5:4]) == 2'b00 |-> int_n_out
  ) else $error("request low with both sources disabled");

  a_change_raises_int: assert property (
    ais_chg && st_reg.ien[RXAI_IRQ_AIS] && !(wr_en_in && addr_in == RXAI_OFF_IEN)
    |=> !int_n_out
  ) else $error("enabled alarm change did not raise request");

  a_idle_change_int: assert property (
    idle_chg && st_reg.ien[RXAI_IRQ_IDLE] && !(wr_en_in && addr_in == RXAI_OFF_IEN)
    |=> !int_n_out
  ) else $error("enabled idle change did not raise request");

  a_unused_flags_zero: assert property (
    st_reg.flags[7:6] == 2'b00 && st_reg.flags[3:0] == 4'h0
  ) else $error("flag outside alarm and idle set");

  a_write_one_clears: assert property (
    wr_en_in && addr_in == RXAI_OFF_FLAGS && wr_data_in[RXAI_IRQ_AIS] && !ais_chg
    |=> !st_reg.flags[RXAI_IRQ_AIS]
  ) else $error("write of one did not clear alarm flag");

  a_rdata_quiet: assert property (
    !rd_en_in |=> rd_data_out == 8'h00
  ) else $error("read data present without a read");

  a_state_mirror: assert property (
    {alarm_indication_state_out, idle_pattern_state_out} == $past({ais_state, idle_state})
  ) else $error("state outputs do not follow detectors");

  a_cfg_write: assert property (
    wr_en_in && addr_in == RXAI_OFF_CFG |=> framing_cfg_out == $past(wr_data_in[2:0])
  ) else $error("framing options not written");

  // Main scenarios: both edges of the alarm and idle conditions, one service
  c_idle_cleared: cover property ($fell(idle_state));
  c_alarm_declared: cover property ($rose(ais_state));
  c_alarm_cleared: cover property ($fell(ais_state));
  c_idle_declared: cover property ($rose(idle_state));
  c_int_serviced: cover property ($fell(int_n_out) ##[1:20] $rose(int_n_out));
endmodule
`default_nettype wire

// ### verilog/rxai_frame_cond.sv
// Frame-count condition detector: declare or clear after a run of frames.
// Assumes one frame strobe per received frame with its pattern flag.
`timescale 1ns/10ps
`default_nettype none
module rxai_frame_cond import rxai_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic frame_in,
  input wire logic pattern_in,
  output logic state_out,
  output logic change_out
);
  typedef struct packed {
    rxai_cond_t cond; // Declared or clear
    logic [5:0] cnt; // Run of disagreeing frames
    logic chg; // One-cycle change pulse
  } rxai_fc_t;
  rxai_fc_t st_reg, st_next;
  // ----------------------------------------
  // Run counter
  // ----------------------------------------
  // Any agreeing frame restarts the run, so noise cannot add up
  always_comb begin
    st_next = st_reg;
    st_next.chg = 1'b0;
    if (frame_in) begin
      if (pattern_in != st_reg.cond) begin
        if (st_reg.cnt == RXAI_FRAME_THRESH - 6'h01) begin
          st_next.cond = rxai_cond_t'(~st_reg.cond);
          st_next.cnt = 6'h00;
          st_next.chg = 1'b1;
        end else begin
          st_next.cnt = st_reg.cnt + 6'h01;
        end
      end else begin
        st_next.cnt = 6'h00;
      end
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_reg <= '{RXAI_CLEAR, 6'h00, 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end
  assign state_out = st_reg.cond;
  assign change_out = st_reg.chg;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  a_declare_after_run: assert property (
    $rose(state_out) |-> $past(st_reg.cnt) == 6'h3e && $past(frame_in)
  ) else $error("condition declared before a full run");
  a_clear_after_run: assert property (
    $fell(state_out) |-> $past(st_reg.cnt) == 6'h3e && !$past(pattern_in)
  ) else $error("condition cleared before a full run");
endmodule
`default_nettype wire

// ### verilog/rxai_oof_det.sv
// Out-of-frame detector over the last sixteen framing bits.
// Assumes a strobe per framing bit and a pulse when framing is regained.
`timescale 1ns/10ps
`default_nettype none
module rxai_oof_det import rxai_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic fbit_in,
  input wire logic fbit_err_in,
  input wire logic six_sel_in,
  input wire logic in_frame_in,
  output logic oof_out
);
  typedef struct packed {
    logic [15:0] hist; // Error history, newest in bit 0
    logic oof; // Out-of-frame declared
  } rxai_oof_t;
  rxai_oof_t st_reg, st_next;
  logic [4:0] errs; // Errors in the new history
  logic [4:0] thr; // Selected threshold
  // ----------------------------------------
  // History and decision
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    errs = 5'h00;
    thr = six_sel_in ? RXAI_OOF_THR_HIGH : RXAI_OOF_THR_LOW;
    if (fbit_in) begin
      st_next.hist = {st_reg.hist[14:0], fbit_err_in};
    end
    for (int i = 0; i < 16; i++) begin
      errs = errs + {4'h0, st_next.hist[i]};
    end
    if (!st_reg.oof && fbit_in && errs >= thr) begin
      st_next.oof = 1'b1;
    end else if (st_reg.oof && in_frame_in) begin
      st_next.oof = 1'b0;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_reg <= '{16'h0000, 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end
  assign oof_out = st_reg.oof;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  a_oof_needs_errors: assert property (
    $rose(oof_out) |-> $countones(st_reg.hist) >= ($past(six_sel_in) ? 6 : 3)
  ) else $error("out-of-frame declared with too few errors");
endmodule
`default_nettype wire

// ### verilog/rxai_pkg.sv
// Shared constants for the receive alarm interrupt block.
// Assumes one byte-wide register port and one system clock.
package rxai_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] RXAI_OFF_CFG = 8'h10;
  localparam logic [7:0] RXAI_OFF_IEN = 8'h12;
  localparam logic [7:0] RXAI_OFF_FLAGS = 8'h13;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int RXAI_CFG_AIS = 7;
  localparam int RXAI_CFG_LOS = 6;
  localparam int RXAI_CFG_IDLE = 5;
  localparam int RXAI_CFG_OOF = 4;
  localparam int RXAI_CFG_PAR = 2;
  localparam int RXAI_CFG_FSYNC = 1;
  localparam int RXAI_CFG_MSYNC = 0;
  localparam int RXAI_IRQ_AIS = 5;
  localparam int RXAI_IRQ_IDLE = 4;
  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  localparam logic [7:0] RXAI_IEN_RST = 8'h00;
  localparam logic [7:0] RXAI_FLAGS_RST = 8'h00;
  localparam logic [2:0] RXAI_CFG_RST = 3'h0;
  // ----------------------------------------
  // Frame and framing-bit counts
  // ----------------------------------------
  localparam logic [5:0] RXAI_FRAME_THRESH = 6'h3f;
  localparam logic [4:0] RXAI_OOF_THR_LOW = 5'h03;
  localparam logic [4:0] RXAI_OOF_THR_HIGH = 5'h06;
  // Condition state of a frame-count detector
  typedef enum logic {
    RXAI_CLEAR = 1'b0,
    RXAI_DECLARED = 1'b1
  } rxai_cond_t;
endpackage
